// ### hdl/ctb_pkg.sv
package ctb_pkg;
  localparam int NUM_BUF   = 3;    // transmit buffers
  localparam int BUF_BYTES = 14;   // bytes per buffer
  localparam int ID_BYTES  = 5;    // identifier bytes
  localparam int PAY_BYTES = 8;    // payload bytes
  // buffer byte index inside a buffer
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_ID0  = 4'h1;
  // control byte bit positions
  localparam int B_ABT = 6;
  localparam int B_LOA = 5;
  localparam int B_ERR = 4;
  localparam int B_REQ = 3;
  localparam int B_PR1 = 1;
  localparam int B_PR0 = 0;
  // byte address map: buffer n at BUF_BASE + n*BUF_STRIDE, one word per byte
  localparam logic [11:0] BUF_BASE   = 12'h000;
  localparam logic [11:0] BUF_STRIDE = 12'h040;
  localparam logic [11:0] A_PINCTRL  = 12'h100;  // request pin control
  localparam logic [11:0] A_MODE     = 12'h104;  // bit0 configuration mode
  localparam logic [11:0] A_INTEN    = 12'h108;  // interrupt enables
  localparam logic [11:0] A_INTFLG   = 12'h10c;  // interrupt flags
  localparam logic [11:0] A_ENGINE   = 12'h110;  // engine status
  // interrupt register bits: 0..2 done per buffer, 3 message error
  localparam int I_MERR = 3;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // frame request handed to the protocol engine
  typedef struct packed {
    logic [1:0]  buf_idx;
    logic [39:0] ident;
    logic [63:0] payload;
  } ctb_frame_s;
  // outcome reported back by the protocol engine
  typedef struct packed {
    logic done;
    logic err;
    logic lost;
  } ctb_result_s;
endpackage : ctb_pkg

// ### hdl/ctb_tx_sched.sv
`timescale 1ns/1ps
module ctb_tx_sched
  import ctb_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NUM_BUF-1:0] request_send_pin_n,
  input  wire logic              bus_idle,
  output logic                   frame_valid,
  output ctb_frame_s             frame,
  input  wire ctb_result_s       result,
  output logic                   irq_q
);
  // buffer storage, byte-wide
  logic [7:0]         mem_q [NUM_BUF][BUF_BYTES];
  logic [NUM_BUF-1:0] req_q, abt_q, loa_q, err_q;
  logic [1:0]         prio_q [NUM_BUF];
  logic [NUM_BUF-1:0] pinctl_q;      // 1 = pin requests its buffer
  logic               cfg_mode_q;    // configuration mode
  logic [3:0]         inten_q;       // done enables and message error enable
  logic [3:0]         intflg_q;      // sticky interrupt flags
  logic [NUM_BUF-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic               busy_q;        // a frame is in flight
  logic [1:0]         cur_q;         // buffer in flight
  // write path registers
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        aw_have_q, w_have_q;
  logic        wr_go;
  logic [NUM_BUF-1:0] pin_fall;
  logic [NUM_BUF-1:0] wr_req_set, wr_req_clr;
  logic               sel_ok;
  logic [1:0]         sel_idx;

  // decode an address into buffer number and byte, valid if mapped
  function automatic logic [6:0] buf_dec(input logic [11:0] a);
    logic [11:0] off;
    logic        ok;
    logic [1:0]  n;
    off = 12'h000;
    ok  = 1'b0;
    n   = 2'h0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (a >= BUF_BASE + 12'(i) * BUF_STRIDE &&
          a <  BUF_BASE + 12'(i) * BUF_STRIDE + 12'(BUF_BYTES * 4) &&
          a[1:0] == 2'h0) begin
        ok  = 1'b1;
        n   = 2'(i);
        off = a - BUF_BASE - 12'(i) * BUF_STRIDE;
      end
    end
    return {ok, n, off[5:2]};
  endfunction : buf_dec

  // decode layout: [6] mapped, [5:4] buffer number, [3:0] byte index
  wire [6:0] wdec = buf_dec(awaddr_q);
  wire [6:0] rdec = buf_dec(s_axi_araddr);
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !wr_go;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !wr_go;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  // write response, error for unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wdec[6] || awaddr_q == A_PINCTRL || awaddr_q == A_MODE ||
                       awaddr_q == A_INTEN || awaddr_q == A_INTFLG ||
                       awaddr_q == A_ENGINE) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // payload storage writes; refused while request pending
  always_ff @(posedge aclk) begin
    if (wr_go && wdec[6] && wdec[3:0] != IDX_CTRL && !req_q[wdec[5:4]]) begin
      mem_q[wdec[5:4]][wdec[3:0]] <= wdata_q[7:0];
    end
  end

  // request pin synchronisers and falling-edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
    end else begin
      pin_s1_q <= request_send_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  assign pin_fall = pin_s3_q & ~pin_s2_q & pinctl_q;

  // per-buffer register-write request set and clear
  generate
    for (genvar g = 0; g < NUM_BUF; g++) begin : g_wr
      wire hit = wr_go && wdec[6] && wdec[5:4] == 2'(g) && wdec[3:0] == IDX_CTRL;
      assign wr_req_set[g] = hit && wdata_q[B_REQ];
      // cancel only when not in flight
      assign wr_req_clr[g] = hit && !wdata_q[B_REQ] && !(busy_q && cur_q == 2'(g));
    end
  endgenerate

  // control byte state per buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= '0;
      abt_q <= '0;
      loa_q <= '0;
      err_q <= '0;
      for (int i = 0; i < NUM_BUF; i++) prio_q[i] <= 2'h0;
    end else begin
      for (int i = 0; i < NUM_BUF; i++) begin
        if (wr_go && wdec[6] && wdec[5:4] == 2'(i) && wdec[3:0] == IDX_CTRL &&
            !(busy_q && cur_q == 2'(i))) begin
          prio_q[i] <= wdata_q[B_PR1:B_PR0];
        end
        if (wr_req_clr[i]) req_q[i] <= 1'b0;
        if (busy_q && cur_q == 2'(i) && result.done) begin
          req_q[i] <= 1'b0;
        end
        if (busy_q && cur_q == 2'(i) && result.err) err_q[i] <= 1'b1;
        if (busy_q && cur_q == 2'(i) && result.lost) loa_q[i] <= 1'b1;
        // a new request wins and wipes old status
        if (wr_req_set[i] || pin_fall[i]) begin
          req_q[i] <= 1'b1;
          abt_q[i] <= 1'b0;
          loa_q[i] <= 1'b0;
          err_q[i] <= 1'b0;
        end
      end
    end
  end

  // priority pick: highest field, ties to higher index
  always_comb begin
    sel_ok  = 1'b0;
    sel_idx = 2'h0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (req_q[i] && (!sel_ok || prio_q[i] >= prio_q[sel_idx])) begin
        sel_ok  = 1'b1;
        sel_idx = 2'(i);
      end
    end
  end

  // launch on idle bus, retry after failure while request holds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q      <= 1'b0;
      cur_q       <= 2'h0;
      frame_valid <= 1'b0;
      frame       <= '0;
    end else if (!busy_q) begin
      frame_valid <= 1'b0;
      if (sel_ok && bus_idle) begin
        busy_q       <= 1'b1;
        cur_q        <= sel_idx;
        frame_valid  <= 1'b1;
        frame.buf_idx <= sel_idx;
        for (int b = 0; b < ID_BYTES; b++) begin
          frame.ident[8*b +: 8] <= mem_q[sel_idx][IDX_ID0 + 4'(b)];
        end
        for (int b = 0; b < PAY_BYTES; b++) begin
          frame.payload[8*b +: 8] <= mem_q[sel_idx][IDX_ID0 + 4'(ID_BYTES + b)];
        end
      end
    end else begin
      frame_valid <= 1'b0;
      if (result.done || result.err || result.lost) busy_q <= 1'b0;
    end
  end

  // mode, pin control, enables and sticky flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_mode_q <= 1'b1;
      pinctl_q   <= '0;
      inten_q    <= 4'h0;
      intflg_q   <= 4'h0;
    end else begin
      if (wr_go && awaddr_q == A_MODE) cfg_mode_q <= wdata_q[0];
      if (wr_go && awaddr_q == A_PINCTRL && cfg_mode_q) begin
        pinctl_q <= wdata_q[NUM_BUF-1:0];
      end
      if (wr_go && awaddr_q == A_INTEN) inten_q <= wdata_q[3:0];
      // writing one clears a flag; hardware set below wins
      if (wr_go && awaddr_q == A_INTFLG) intflg_q <= intflg_q & ~wdata_q[3:0];
      if (busy_q && result.done) intflg_q[cur_q] <= 1'b1;
      if (busy_q && result.err) intflg_q[I_MERR] <= 1'b1;
    end
  end

  // interrupt output from enabled flags
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_q <= 1'b0;
    else irq_q <= |(intflg_q & inten_q);
  end

  // read channel, one-cycle answer after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OK;
        s_axi_rdata  <= 32'h0000_0000;
        if (rdec[6] && rdec[3:0] == IDX_CTRL) begin
          // unused control bits read zero
          s_axi_rdata[B_ABT]       <= abt_q[rdec[5:4]];
          s_axi_rdata[B_LOA]       <= loa_q[rdec[5:4]];
          s_axi_rdata[B_ERR]       <= err_q[rdec[5:4]];
          s_axi_rdata[B_REQ]       <= req_q[rdec[5:4]];
          s_axi_rdata[B_PR1:B_PR0] <= prio_q[rdec[5:4]];
        end else if (rdec[6]) s_axi_rdata[7:0] <= mem_q[rdec[5:4]][rdec[3:0]];
        else if (s_axi_araddr == A_PINCTRL) begin
          s_axi_rdata[2*NUM_BUF-1:0] <= {~pin_s2_q, pinctl_q};
        end
        else if (s_axi_araddr == A_MODE) s_axi_rdata[0] <= cfg_mode_q;
        else if (s_axi_araddr == A_INTEN) s_axi_rdata[3:0] <= inten_q;
        else if (s_axi_araddr == A_INTFLG) s_axi_rdata[3:0] <= intflg_q;
        else if (s_axi_araddr == A_ENGINE) s_axi_rdata[2:0] <= {cur_q, busy_q};
        else s_axi_rresp <= RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : ctb_tx_sched

// ### testbench/ctb_tx_sched_chk.sv
`timescale 1ns/1ps
module ctb_tx_sched_chk
  import ctb_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        bus_idle,
  input wire logic        frame_valid,
  input wire logic        irq_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read address accepted
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  // frame handed over after a free bus
  sequence s_launch; bus_idle ##1 frame_valid; endsequence
  chk_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_ERR |-> s_axi_rdata == 32'h0)
    else $error("refused read data not zero");
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready not a pulse");
  chk_launch_idle: assert property (frame_valid |-> $past(bus_idle))
    else $error("launch without free bus");
  chk_busy_hold: assert property (!bus_idle |=> !frame_valid)
    else $error("launch while bus busy");
  chk_one_flight: assert property (s_launch |=> !frame_valid [*3])
    else $error("second launch in flight");
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !frame_valid && !irq_q && !s_axi_bvalid)
    else $error("outputs active in reset");
endmodule : ctb_tx_sched_chk
bind ctb_tx_sched ctb_tx_sched_chk u_ctb_tx_sched_chk (.*);

// ### testbench/ctb_engine_model.sv
`timescale 1ns/1ps
module ctb_engine_model
  import ctb_pkg::*;
#(parameter int DLY = 20)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       frame_valid,
  input wire logic       hold,
  input wire logic [1:0] mode,
  output logic           bus_idle,
  output ctb_result_s    result
);
  int cnt_q;  // cycles left in flight
  // one outcome pulse per frame, kind set by mode, no pulse for mode 3
  always_ff @(posedge aclk) begin
    result <= '0;
    if (!aresetn) cnt_q <= 0;
    else if (frame_valid) cnt_q <= DLY;
    else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) result <= '{mode == 2'h0, mode == 2'h1, mode == 2'h2};
    end
  end
  // bus free outside frames unless the bench holds it
  assign bus_idle = (cnt_q == 0) && !hold && !frame_valid;
endmodule : ctb_engine_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ctb_pkg::*;
  logic aclk = 0, aresetn = 0, hold = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, v_ok;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v, rs = 32'd63860;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] request_send_pin_n = 3'h7;
  logic [1:0] mode = 0, s_axi_bresp, s_axi_rresp, p[NUM_BUF];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic frame_valid, bus_idle, irq_q;
  ctb_frame_s frame, exp_f[NUM_BUF], fr_q[$];
  ctb_result_s result;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  int error_cnt = 0, checks = 0, cyc = 0;
  always #5 aclk = ~aclk;
  ctb_tx_sched u_ctb_tx_sched (.*);
  ctb_engine_model u_ctb_engine_model (.*);
  // xorshift source
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  // byte address of buffer i, byte k
  function automatic logic [11:0] ba(input int i, input int k);
    return 12'(BUF_BASE + BUF_STRIDE * i + 4 * k);
  endfunction : ba
  task automatic cmp(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // write one byte, expect response r
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    wr_q.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awready && !ta) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !tw) s_axi_wvalid <= 1'b0;
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  // read, note expected response and data
  task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d);
    rd_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  // free the bus until every noted frame left, then hold it again
  task automatic go();
    hold <= 1'b0;
    while (fr_q.size() > 0) @(posedge aclk);
    hold <= 1'b1;
  endtask : go
  task automatic fin();
    do @(posedge aclk); while (!(result.done || result.err || result.lost));
  endtask : fin
  // monitor: oldest note against each answer and launch
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp("read", rd_q.size() ? rd_q.pop_front() : 'x,
      {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", wr_q.size() ? wr_q.pop_front() : 'x,
      s_axi_bresp);
    if (frame_valid) cmp("frame", fr_q.size() ? fr_q.pop_front() : 'x, frame);
  end
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NUM_BUF; i++) rd(ba(i, 0), RESP_OK, 0);
    rd(A_MODE, RESP_OK, 1);
    rd(A_PINCTRL, RESP_OK, 0);
    rd(12'h1f0, RESP_ERR, 0);
    wr(12'h1f0, 8'h00, RESP_ERR);
    wr(A_INTEN, 8'h0f, RESP_OK);
    // random identifier and payload in every buffer
    for (int i = 0; i < NUM_BUF; i++) begin
      exp_f[i].buf_idx = 2'(i);
      for (int k = 0; k < BUF_BYTES - 1; k++) begin
        v = rnd();
        wr(ba(i, k + 1), v[7:0], RESP_OK);
        if (k < ID_BYTES) exp_f[i].ident[8*k+:8] = v[7:0];
        else exp_f[i].payload[8*(k-ID_BYTES)+:8] = v[7:0];
      end
    end
    // priority rounds, first round all equal
    for (int n = 0; n < 6; n++) begin
      v = rnd();
      for (int i = 0; i < NUM_BUF; i++) begin
        p[i] = (n == 0) ? v[1:0] : v[2*i+:2];
        wr(ba(i, 0), 8'h08 | p[i], RESP_OK);
        rd(ba(i, 0), RESP_OK, 8'h08 | p[i]);
      end
      for (int l = 3; l >= 0; l--) for (int i = NUM_BUF - 1; i >= 0; i--)
        if (p[i] == 2'(l)) fr_q.push_back(exp_f[i]);
      go();
      fin();
      for (int i = 0; i < NUM_BUF; i++) rd(ba(i, 0), RESP_OK, 32'(p[i]));
      rd(A_INTFLG, RESP_OK, 7);
      cmp("irq", 1, irq_q);
      wr(A_INTFLG, 8'h0f, RESP_OK);
      @(posedge aclk);
      cmp("irq", 0, irq_q);
    end
    // error, then lost arbitration, on buffer 0
    mode <= 2'h1;
    wr(ba(0, 0), 8'h08, RESP_OK);
    fr_q.push_back(exp_f[0]);
    go();
    fin();
    rd(ba(0, 0), RESP_OK, 8'h18);
    rd(A_INTFLG, RESP_OK, 8);
    cmp("irq", 1, irq_q);
    mode <= 2'h2;
    fr_q.push_back(exp_f[0]);
    go();
    fin();
    rd(ba(0, 0), RESP_OK, 8'h38);
    wr(ba(0, 0), 8'h00, RESP_OK);
    rd(ba(0, 0), RESP_OK, 8'h30);
    wr(ba(0, 0), 8'h08, RESP_OK);
    rd(ba(0, 0), RESP_OK, 8'h08);
    mode <= 2'h0;
    fr_q.push_back(exp_f[0]);
    go();
    wr(ba(0, 0), 8'h00, RESP_OK);
    rd(ba(0, 0), RESP_OK, 8'h08);
    fin();
    rd(ba(0, 0), RESP_OK, 0);
    // pins: plain input first, then request input, then locked
    request_send_pin_n <= 3'h5;
    repeat (4) @(posedge aclk);
    rd(A_PINCTRL, RESP_OK, 8'h10);
    rd(ba(1, 0), RESP_OK, 32'(p[1]));
    request_send_pin_n <= 3'h7;
    wr(A_PINCTRL, 8'h07, RESP_OK);
    wr(A_MODE, 8'h00, RESP_OK);
    wr(A_PINCTRL, 8'h00, RESP_OK);
    rd(A_PINCTRL, RESP_OK, 7);
    request_send_pin_n <= 3'h3;
    repeat (4) @(posedge aclk);
    rd(ba(2, 0), RESP_OK, 8'h08 | p[2]);
    fr_q.push_back(exp_f[2]);
    go();
    fin();
    complete_run();
  end
endmodule : tb_top
